// [tsrb_pkg.sv]
/*
  Package for the temperature sensor register bank: register selector
  codes, configuration field layout, reset values and conversion timing.
  Assumes a single 200 MHz core clock and a two-wire serial bus link.
*/
package tsrb_pkg;

  // ----------------------------------------------------------------
  // Register selector codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_RESULT = 2'h0;
  localparam logic [1:0] SEL_SETUP  = 2'h1;
  localparam logic [1:0] SEL_LOWER  = 2'h2;
  localparam logic [1:0] SEL_UPPER  = 2'h3;
  localparam logic [5:0] SEL_UNUSED = 6'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0]  SETUP_RESET  = 8'h00;
  localparam logic [8:0]  LOWER_RESET  = 9'h096;  // 75 degrees
  localparam logic [8:0]  UPPER_RESET  = 9'h0a0;  // 80 degrees
  localparam logic [1:0]  SEL_RESET    = 2'h0;

  // ----------------------------------------------------------------
  // Result and limit layout
  // ----------------------------------------------------------------
  localparam int          CODE_W       = 12;
  localparam int          LIMIT_W      = 9;
  localparam logic [3:0]  RESULT_PAD   = 4'h0;
  localparam logic [6:0]  LIMIT_PAD    = 7'h00;

  // ----------------------------------------------------------------
  // Bus address: fixed upper nibble, low three bits from straps
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_HIGH    = 4'h9;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 200000;
  localparam int unsigned CONV_9BIT_MS  = 30;
  localparam int unsigned CONV_12BIT_MS = 240;
  localparam int unsigned CONV_9BIT_CYC = CONV_9BIT_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Configuration register layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       one_shot;
    logic [1:0] resolution;
    logic [1:0] fault_queue;
    logic       alert_high;
    logic       irq_mode;
    logic       shutdown;
  } tsrb_setup_t;

  // Two-wire link pins as seen by the device
  typedef struct packed {
    logic scl;
    logic sda;
  } tsrb_link_t;

endpackage

// [tsrb_top.sv]
/*
  Register bank of a two-wire temperature sensor: bus slave, register
  selector, setup, limits and the double-buffered result with its
  conversion timer.
  Assumes link pins arrive asynchronously, an external pull-up resolves
  the data line, and the converter code input is on ref_clk.
*/
// How it works
// - Selector 00 result, 01 setup, 10/11 limits
// - Result is 16-bit read-only two's complement
// - Refresh 30 ms at 9 bits, 240 at 12
// - Result double-buffered; reads see completed value
// - Result code weight is one sixteenth degree
// - Sign bit 15, integer 14..8, fraction 7..4
// - Fraction bits below resolution read zero
// - Setup is 8-bit read/write, resets zero
// - Setup bit 7 requests single conversion
// - Setup bits 6..5 select resolution
// - Setup bits 4..3 set fault count
// - Setup bit 2 sets alert polarity
// - Setup bit 1 picks interrupt or comparator
// - Setup bit 0 enters shutdown
// - Limits keep nine upper bits only
// - One-shot only from shutdown; self-clears after update
// - Limits reset to 75 and 80 degrees
module tsrb_top #(
  parameter int unsigned CONV_9BIT_CYCLES = tsrb_pkg::CONV_9BIT_CYC
) (
  // Clock, reset, enable
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  // Two-wire link pins and address straps
  input  wire tsrb_pkg::tsrb_link_t          link_in,
  input  wire logic [2:0]                    addr_strap,
  output logic                               sda_out,
  output logic                               sda_oe,
  // Converter code from the analog front end
  input  wire logic signed [11:0]            adc_code,
  // Register contents for the alert logic
  output tsrb_pkg::tsrb_setup_t              setup,
  output logic [15:0]                        result,
  output logic [15:0]                        lower_limit,
  output logic [15:0]                        upper_limit,
  output logic [7:0]                         register_selector,
  output logic                               conv_done
);
  import tsrb_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
  } tsrb_state_t;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Mask of result bits kept at a resolution
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    logic [15:0] m;
    m = 16'hff80;
    unique case (res)
      2'h0: m = 16'hff80;
      2'h1: m = 16'hffc0;
      2'h2: m = 16'hffe0;
      2'h3: m = 16'hfff0;
    endcase
    return m;
  endfunction

  // Conversion length doubles per extra bit of resolution
  function automatic logic [31:0] conv_len(input logic [1:0] res);
    return 32'(CONV_9BIT_CYCLES) << res;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  tsrb_link_t link_meta;
  tsrb_link_t link_sync;
  tsrb_link_t link_prev;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;

  // Two flops on every pin, third flop for edges
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      link_meta  <= 2'h3;
      link_sync  <= 2'h3;
      link_prev  <= 2'h3;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else if (ce) begin
      link_meta  <= link_in;
      link_sync  <= link_meta;
      link_prev  <= link_sync;
      strap_meta <= addr_strap;
      strap_sync <= strap_meta;
    end
  end

  wire scl_rise = link_sync.scl & ~link_prev.scl;
  wire scl_fall = ~link_sync.scl & link_prev.scl;
  wire start_ev = link_sync.scl & link_prev.scl & link_prev.sda & ~link_sync.sda;
  wire stop_ev  = link_sync.scl & link_prev.scl & ~link_prev.sda & link_sync.sda;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  tsrb_state_t state;
  tsrb_state_t next_state;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [2:0]  bit_cnt;
  logic        ack_on;
  logic        byte_idx;
  logic [7:0]  wr_msb;
  logic [15:0] snap;
  logic [1:0]  sel_field;

  // Receive-side decoding
  wire         rx_state  = (state == ST_ADDR) || (state == ST_PTR) || (state == ST_WDATA);
  wire         byte_done = rx_state && scl_rise && (bit_cnt == 3'h7);
  wire [7:0]   rx_byte   = {rx_shift[6:0], link_sync.sda};
  wire         addr_hit  = (rx_byte[7:1] == {ADDR_HIGH, strap_sync});
  wire         ack_end   = scl_fall && ack_on;

  // Register read selection, snapshot taken as the address byte completes
  wire [15:0]  sel_value =
    (sel_field == SEL_RESULT) ? result :
    (sel_field == SEL_SETUP)  ? {setup, setup} :
    (sel_field == SEL_LOWER)  ? lower_limit : upper_limit;
  wire [7:0]   tx_next   = byte_idx ? snap[7:0] : snap[15:8];

  // Host write strobes
  wire wr_data   = byte_done && (state == ST_WDATA);
  wire wr_setup  = wr_data && (sel_field == SEL_SETUP);
  wire wr_lo_msb = wr_data && !byte_idx;
  wire wr_lower  = wr_data && byte_idx && (sel_field == SEL_LOWER);
  wire wr_upper  = wr_data && byte_idx && (sel_field == SEL_UPPER);

  // Next state of the bus slave
  always_comb begin
    next_state = state;
    if (start_ev) begin
      next_state = ST_ADDR;
    end else if (stop_ev) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:      next_state = ST_IDLE;
        ST_ADDR:      if (byte_done) next_state = addr_hit ? ST_ACK_ADDR : ST_IDLE;
        ST_ACK_ADDR:  if (ack_end) next_state = rx_shift[0] ? ST_RDATA : ST_PTR;
        ST_PTR:       if (byte_done) next_state = ST_ACK_PTR;
        ST_ACK_PTR:   if (ack_end) next_state = ST_WDATA;
        ST_WDATA:     if (byte_done) next_state = ST_ACK_WDATA;
        ST_ACK_WDATA: if (ack_end) next_state = ST_WDATA;
        ST_RDATA:     if (scl_fall && bit_cnt == 3'h7) next_state = ST_RACK;
        ST_RACK: begin
          if (scl_rise && link_sync.sda) next_state = ST_IDLE;
          else if (scl_fall) next_state = ST_RDATA;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) state <= ST_IDLE;
    else if (ce) state <= next_state;
  end

  // Bit counter and receive shifter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bit_cnt  <= 3'h0;
      rx_shift <= 8'h00;
    end else if (ce) begin
      if (start_ev || ack_end || (state == ST_RACK && scl_fall)) bit_cnt <= 3'h0;
      else if (rx_state && scl_rise) bit_cnt <= bit_cnt + 3'h1;
      else if (state == ST_RDATA && scl_fall) bit_cnt <= bit_cnt + 3'h1;
      if (rx_state && scl_rise) rx_shift <= rx_byte;
    end
  end

  // Ack drive: on from first fall after the byte to the next fall
  always_ff @(posedge ref_clk) begin
    if (!nrst) ack_on <= 1'b0;
    else if (ce) begin
      if (start_ev || stop_ev) ack_on <= 1'b0;
      else if (ack_end) ack_on <= 1'b0;
      else if (scl_fall && (state == ST_ACK_ADDR || state == ST_ACK_PTR
                            || state == ST_ACK_WDATA)) ack_on <= 1'b1;
    end
  end

  // Byte index within a wide register, and read snapshot
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      byte_idx <= 1'b0;
      snap     <= 16'h0000;
    end else if (ce) begin
      if (start_ev) byte_idx <= 1'b0;
      else if (wr_data) byte_idx <= ~byte_idx;
      else if (state == ST_RDATA && scl_fall && bit_cnt == 3'h7) byte_idx <= ~byte_idx;
      if (byte_done && state == ST_ADDR) snap <= sel_value;
    end
  end

  // Transmit shifter, loaded when a read byte begins
  always_ff @(posedge ref_clk) begin
    if (!nrst) tx_shift <= 8'hff;
    else if (ce) begin
      if ((state == ST_ACK_ADDR && ack_end && rx_shift[0])
          || (state == ST_RACK && scl_fall)) tx_shift <= tx_next;
      else if (state == ST_RDATA && scl_fall) tx_shift <= {tx_shift[6:0], 1'b1};
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = ack_on || (state == ST_RDATA && !tx_shift[7]);

  // ----------------------------------------------------------------
  // Register selector and limits
  // ----------------------------------------------------------------
  // Selector keeps only its low two bits
  always_ff @(posedge ref_clk) begin
    if (!nrst) sel_field <= SEL_RESET;
    else if (ce && byte_done && state == ST_PTR) sel_field <= rx_byte[1:0];
  end
  assign register_selector = {SEL_UNUSED, sel_field};

  logic [8:0] lower_q;
  logic [8:0] upper_q;

  // Limits store nine upper bits; first byte is held until the second
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_msb  <= 8'h00;
      lower_q <= LOWER_RESET;
      upper_q <= UPPER_RESET;
    end else if (ce) begin
      if (wr_lo_msb) wr_msb <= rx_byte;
      if (wr_lower) lower_q <= {wr_msb, rx_byte[7]};
      if (wr_upper) upper_q <= {wr_msb, rx_byte[7]};
    end
  end
  assign lower_limit = {lower_q, LIMIT_PAD};
  assign upper_limit = {upper_q, LIMIT_PAD};

  // ----------------------------------------------------------------
  // Setup register and one-shot
  // ----------------------------------------------------------------
  logic        one_shot_run;
  logic [31:0] conv_cnt;
  wire         conv_run  = !setup.shutdown || one_shot_run;
  wire         conv_end  = conv_run && (conv_cnt >= conv_len(setup.resolution) - 32'h1);
  wire         shot_req  = wr_setup && setup.shutdown && rx_byte[7] && rx_byte[0];

  // Host write wins over the self-clear of the one-shot bit
  always_ff @(posedge ref_clk) begin
    if (!nrst) setup <= SETUP_RESET;
    else if (ce) begin
      if (wr_setup) setup <= rx_byte;
      else if (conv_end) setup.one_shot <= 1'b0;
    end
  end

  // Single conversion only armed from shutdown
  always_ff @(posedge ref_clk) begin
    if (!nrst) one_shot_run <= 1'b0;
    else if (ce) begin
      if (shot_req) one_shot_run <= 1'b1;
      else if (conv_end) one_shot_run <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion timer and result buffer
  // ----------------------------------------------------------------
  // Counts one conversion period per resolution
  always_ff @(posedge ref_clk) begin
    if (!nrst) conv_cnt <= 32'h0;
    else if (ce) begin
      if (!conv_run || conv_end) conv_cnt <= 32'h0;
      else conv_cnt <= conv_cnt + 32'h1;
    end
  end

  // Result loads only at the end of a conversion
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      result    <= RESULT_RESET;
      conv_done <= 1'b0;
    end else if (ce) begin
      conv_done <= conv_end;
      if (conv_end)
        result <= {adc_code, RESULT_PAD}
                  & res_mask(setup.resolution);
    end
  end

endmodule

// [tsrb_chk.sv]
/* Assertions on the register bank's ports.
   Assumes a bind to tsrb_top, one ref_clk domain and ce held high. */
module tsrb_chk #(
  parameter int unsigned CONV_9BIT_CYCLES = 40
) (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  // Register outputs
  input wire tsrb_pkg::tsrb_setup_t setup,
  input wire logic [15:0]           result,
  input wire logic [15:0]           lower_limit,
  input wire logic [15:0]           upper_limit,
  input wire logic [7:0]            register_selector,
  input wire logic                  conv_done
);
  import tsrb_pkg::*;
  logic [31:0] gap;
  logic        gap_ok;
  tsrb_setup_t last;
  // Cycles between pulses, trusted only while setup holds
  always_ff @(posedge ref_clk) begin
    last   <= setup;
    gap    <= conv_done ? 32'h1 : gap + 32'h1;
    gap_ok <= nrst && (conv_done || (gap_ok && setup == last));
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_rst;
    $rose(nrst) |-> setup == 8'h00 && result == 16'h0000 && register_selector == 8'h00
      && lower_limit == 16'h4b00 && upper_limit == 16'h5000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_sel;
    register_selector[7:2] == 6'h00;
  endproperty
  a_sel: assert property (p_sel) else $error("selector high bits set");
  property p_lim;
    lower_limit[6:0] == 7'h00 && upper_limit[6:0] == 7'h00;
  endproperty
  a_lim: assert property (p_lim) else $error("limit low bits set");
  property p_pad;
    result[3:0] == 4'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("result pad bits set");
  property p_mask;
    conv_done && $stable(setup.resolution) |-> (result[6:4] & (3'h7 >> setup.resolution)) == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("fraction below resolution");
  property p_hold;
    !$stable(result) |-> conv_done;
  endproperty
  a_hold: assert property (p_hold) else $error("result moved off conversion");
  property p_quiet;
    conv_done |-> !$past(setup.shutdown, 2) || $past(setup.one_shot, 2);
  endproperty
  a_quiet: assert property (p_quiet) else $error("conversion in shutdown");
  property p_period;
    conv_done && gap_ok |-> gap == (CONV_9BIT_CYCLES << last.resolution);
  endproperty
  a_period: assert property (p_period) else $error("conversion period wrong");
endmodule

// [tsrb_master.sv]
/* Two-wire bus master model for the sensor's link pins.
   Assumes the bench resolves the data line with a pull-up. */
module tsrb_master (
  // Link lines, data released when high
  output logic     scl,
  output logic     sda_drv,
  // Resolved data line
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Acknowledges the device failed to give
  int nak_count = 0;
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Start when a is high, stop when low
  task automatic frame(input logic a);
    #16 sda_drv = a;
    #16 scl = 1'b1;
    #16 sda_drv = ~a;
    #16 scl = ~a;
  endtask
  // One bit, data set while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #16 sda_drv = b;
    #16 scl = 1'b1;
    #16 r = sda_in;
    #16 scl = 1'b0;
  endtask
  // Byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak, a);
  endtask
  // Byte to the device, counting any missing acknowledge
  task automatic xfer_ack(input logic [7:0] tx);
    logic [7:0] rx;
    logic       a;
    xfer(tx, 1'b1, rx, a);
    if (a !== 1'b0) nak_count++;
  endtask
  // Write frame: address, selector, data bytes
  task automatic wr(input logic [6:0] adr, input logic [7:0] sel, input logic [15:0] d,
                    input logic with_data);
    int         n;
    n = !with_data ? 0 : (sel[1:0] == 2'h1) ? 1 : 2;
    #1.3;
    frame(1'b1);
    xfer_ack({adr, 1'b0});
    xfer_ack({6'h00, sel[1:0]});
    for (int i = n - 1; i >= 0; i--) xfer_ack(d[8 * i +: 8]);
    frame(1'b0);
  endtask
  // Read after a selector write frame, last byte refused
  task automatic rd(input logic [6:0] adr, input logic [7:0] sel, output logic [15:0] d);
    logic       a;
    int         n;
    n = (sel[1:0] == 2'h1) ? 1 : 2;
    d = 16'h0000;
    wr(adr, sel, 16'h0000, 1'b0);
    frame(1'b1);
    xfer_ack({adr, 1'b1});
    for (int i = n - 1; i >= 0; i--) xfer(8'hff, i == 0, d[8 * i +: 8], a);
    frame(1'b0);
  endtask
endmodule

// [tsrb_bench.sv]
/* Self-checking bench for tsrb_top with a bus master model.
   Assumes the data line has a pull-up and ce stays high. */
module tsrb_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import tsrb_pkg::*;
  localparam logic [6:0] ADR = {ADDR_HIGH, 3'h5};
  logic               ref_clk = 1'b0;
  logic               nrst = 1'b0;
  logic signed [11:0] adc_code = 12'sh000;
  logic               scl;
  logic               sda_m;
  logic               sda_oe;
  logic               sda_out;
  logic               conv_done;
  tsrb_link_t         link_in;
  tsrb_setup_t        setup;
  tsrb_setup_t        cfg;
  logic [15:0]        result;
  logic [15:0]        lower_limit;
  logic [15:0]        upper_limit;
  logic [7:0]         register_selector;
  logic [15:0]        d;
  logic [15:0]        want;
  logic [15:0]        seen;
  logic [31:0]        rng = 32'ha639;
  logic [15:0]        exp_q[$];
  string              what_q[$];
  event               got;
  int                 bad_count = 0;
  int                 n_tests = 0;
  // Wired data line with pull-up
  assign link_in.scl = scl;
  assign link_in.sda = sda_m & ~(sda_oe & ~sda_out);
  always #2.5 ref_clk = ~ref_clk;
  tsrb_top #(.CONV_9BIT_CYCLES(40)) dut (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
    .link_in(link_in), .addr_strap(3'h5), .sda_out(sda_out), .sda_oe(sda_oe),
    .adc_code(adc_code), .setup(setup), .result(result), .lower_limit(lower_limit),
    .upper_limit(upper_limit), .register_selector(register_selector), .conv_done(conv_done));
  tsrb_master mst (.scl(scl), .sda_drv(sda_m), .sda_in(link_in.sda));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic close_out;
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // Note an expectation and hand over the result
  task automatic note(input string w, input logic [15:0] e, input logic [15:0] g);
    what_q.push_back(w);
    exp_q.push_back(e);
    seen = g;
    -> got;
    #1;
  endtask
  // Oldest note against each result
  always @(got) cmp16(what_q.pop_front(), exp_q.pop_front(), seen);
  task automatic wait_conv;
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (conv_done !== 1'b1 && i < 3000);
    cmp16("conversion done", 16'h0001, {15'h0000, conv_done});
  endtask
  task automatic check_reset;
    @(posedge ref_clk);
    nrst <= 1'b0;
    adc_code <= 12'sh000;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    note("setup", 16'h0000, {8'h00, setup});
    note("lower", 16'h4b00, lower_limit);
    note("upper", 16'h5000, upper_limit);
    mst.rd(ADR, 8'h00, d);
    note("result", 16'h0000, d);
  endtask
  // Watchdog
  initial begin
    #300us;
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    check_reset();
    for (int r = 0; r < 4; r++) begin
      rng = xs(rng);
      cfg = {1'b0, 2'(r), rng[1:0], rng[2], rng[3], 1'b0};
      mst.wr(ADR, 8'h01, {8'h00, cfg}, 1'b1);
      mst.rd(ADR, 8'h01, d);
      note("setup read", {8'h00, cfg}, d);
      note("setup port", {8'h00, cfg}, {8'h00, setup});
      wait_conv();
      adc_code <= rng[15:4];
      wait_conv();
      want = {rng[15:4] & (12'hfff << (3 - r)), 4'h0};
      note("result port", want, result);
      mst.rd(ADR, 8'h00, d);
      note("result read", want, d);
    end
    mst.wr(ADR, 8'h00, ~want, 1'b1);
    note("result kept", want, result);
    rng = xs(rng);
    mst.wr(ADR, 8'h02, rng[15:0], 1'b1);
    mst.wr(ADR, 8'h03, 16'hffff, 1'b1);
    note("lower port", rng[15:0] & 16'hff80, lower_limit);
    mst.rd(ADR, 8'h03, d);
    note("upper read", 16'hff80, d);
    mst.wr(ADR, 8'hfe, 16'h0000, 1'b0);
    note("selector", 16'h0002, {8'h00, register_selector});
    @(posedge ref_clk);
    adc_code <= rng[31:20];
    mst.wr(ADR, 8'h01, 16'h0001, 1'b1);
    mst.wr(ADR, 8'h01, 16'h0081, 1'b1);
    wait_conv();
    @(posedge ref_clk);
    note("single result", {rng[31:20] & 12'hff8, 4'h0}, result);
    note("single clear", 16'h0001, {8'h00, setup});
    note("device acks", 16'h0000, 16'(mst.nak_count));
    check_reset();
    close_out();
  end
endmodule
bind tsrb_top tsrb_chk #(.CONV_9BIT_CYCLES(CONV_9BIT_CYCLES)) u_chk (.ref_clk(ref_clk),
  .nrst(nrst), .setup(setup), .result(result), .lower_limit(lower_limit),
  .upper_limit(upper_limit), .register_selector(register_selector), .conv_done(conv_done));
